// *** adr_map.svh ***
// register offsets, field positions, codes and reset values of the audio data router
`ifndef ADR_MAP_SVH
`define ADR_MAP_SVH

// register offsets (7-bit control address)
`define ADR_OFF_CLK_OVR 7'h06
`define ADR_OFF_CLK_SEL 7'h08
`define ADR_OFF_PRI_CTRL3 7'h0c
`define ADR_OFF_PRI_CTRL4 7'h0d
`define ADR_OFF_SEC_CTRL2 7'h0e
`define ADR_OFF_SPTX_CTRL0 7'h1e

// field positions
`define ADR_SRC_MSB 8
`define ADR_SRC_LSB 7
`define ADR_SPTX_SRC_MSB 1
`define ADR_SPTX_SRC_LSB 0
`define ADR_THRU_BIT 3
`define ADR_MAN_BIT 6
`define ADR_DACCLK_MSB 1
`define ADR_DACCLK_LSB 0
`define ADR_ADCCLK_MSB 3
`define ADR_ADCCLK_LSB 2
`define ADR_TXCLK_MSB 5
`define ADR_TXCLK_LSB 4

// source codes, shared by all four source fields
`define ADR_CODE_SPDIF 2'h0
`define ADR_CODE_ADC 2'h1
`define ADR_CODE_SEC 2'h2
`define ADR_CODE_PRI 2'h3

// legal codes per field, one bit per code
`define ADR_MASK_DAC1 4'hd
`define ADR_MASK_PRI_TX 4'h7
`define ADR_MASK_SEC_TX 4'hb
`define ADR_MASK_SPTX 4'hf

// clock select codes
`define ADR_DCLK_MCLK 2'h0
`define ADR_DCLK_PLLA 2'h1
`define ADR_DCLK_PLLB 2'h2
`define ADR_ACLK_MCLK 2'h0
`define ADR_ACLK_ADC_MASTER_CLOCK_IN 2'h1
`define ADR_ACLK_PLLA 2'h2
`define ADR_ACLK_PLLB 2'h3

// reset values
`define ADR_RST_DAC1_SRC 2'h3
`define ADR_RST_PRI_TX_SRC 2'h1
`define ADR_RST_SEC_TX_SRC 2'h0
`define ADR_RST_SPTX_SRC 2'h0
`define ADR_RST_THRU 1'h0
`define ADR_RST_MAN 1'h0
`define ADR_RST_CLKSEL 2'h0

`endif

// *** adr_pkg.sv ***
// types of the audio data router
package adr_pkg;

    // candidate clocks; PLL clocks are taken after their output dividers
    typedef enum logic [1:0] {
        CLK_MCLK,
        CLK_ADC_MCLK,
        CLK_PLL_A,
        CLK_PLL_B
    } adr_clk_src_t;

    typedef struct packed {
        logic [1:0] dac1_src;
        logic [1:0] pri_tx_src;
        logic [1:0] sec_tx_src;
        logic [1:0] sptx_src;
        logic thru;
        logic manual;
        logic [1:0] dac_clk_sel;
        logic [1:0] adc_clk_sel;
        logic [1:0] tx_clk_sel;
    } adr_regs_t;

    // on-chip serial sources, same clock
    typedef struct packed {
        logic spdif_rx;
        logic sec_rx;
        logic adc;
        logic sptx_serial;
    } adr_src_in_t;

    typedef struct packed {
        logic [2:0] dac;
        logic pri_tx;
        logic sec_tx;
        logic spdif_tx;
        logic spdif_pin;
        logic dac23_on;
    } adr_data_out_t;

    typedef struct packed {
        adr_clk_src_t dac;
        adr_clk_src_t adc;
        adr_clk_src_t tx;
    } adr_clk_out_t;

    typedef struct packed {
        adr_regs_t regs;
        logic [2:0] din_s1;
        logic [2:0] din_s2;
        logic raw_s1;
        logic raw_s2;
        adr_data_out_t dout;
        adr_clk_out_t ckout;
        logic [8:0] rdata;
        logic rvalid;
    } adr_state_t;

endpackage

// *** adr_router.sv ***
// audio data and clock routing fabric
//
// Contract
// - any of three converter serial inputs can be steered to any of three DACs.
// - the input steered to DAC1 also feeds S/PDIF and secondary transmitters.
// - DAC2 and DAC3 only take primary receiver data.
// - DAC1 source field 8:7, 00 spdif, 10 secondary, 11 primary; 00 may stop DAC2/3.
// - primary transmitter source 8:7: 00 spdif, 01 ADC (reset), 10 secondary.
// - secondary transmitter source 8:7: 00 spdif (reset), 01 ADC, 11 primary.
// - S/PDIF transmitter source 1:0: 00 spdif, 01 ADC, 10 secondary, 11 primary.
// - bit 3 set routes raw S/PDIF input mux to the output pin.
// - block clocks chosen from master, ADC master and two PLL clocks.
// - each block clock mux offers only its permitted subset of clocks.
// - S/PDIF data on DAC1 auto-configures the DAC clock.
// - PLL clocks offered are taken after their output dividers.
// - DAC clock select derives from field 1:0 plus routing.
// - ADC clock select derives from its field plus routing.
// - manual override bit 6 of register 6 uses user fields directly.
// - S/PDIF data on DAC1 forces PLL A as DAC clock when automatic.
// - ADC clock field at 3:2 and transmitter clock field at 5:4 of register 8.
`timescale 1ns/100ps
`include "adr_map.svh"

module adr_router
    import adr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    output logic [8:0] reg_rdata,
    output logic reg_rvalid,
    // serial data pins
    input wire logic [2:0] converter_serial_inputs,
    input wire logic spdif_in_raw,
    // primary receiver steering, two bits per DAC
    input wire logic [2:0][1:0] dac_pin_route,
    input wire logic receiver_dac_sync_mode,
    // on-chip serial sources
    input wire adr_src_in_t src_in,
    // routed data
    output adr_data_out_t data_out,
    // clock mux selects
    output adr_clk_out_t clk_sel
);

    localparam adr_regs_t REGS_RST = '{
        dac1_src: `ADR_RST_DAC1_SRC,
        pri_tx_src: `ADR_RST_PRI_TX_SRC,
        sec_tx_src: `ADR_RST_SEC_TX_SRC,
        sptx_src: `ADR_RST_SPTX_SRC,
        thru: `ADR_RST_THRU,
        manual: `ADR_RST_MAN,
        dac_clk_sel: `ADR_RST_CLKSEL,
        adc_clk_sel: `ADR_RST_CLKSEL,
        tx_clk_sel: `ADR_RST_CLKSEL
    };

    localparam adr_state_t STATE_RST = '{
        regs: REGS_RST,
        din_s1: '0,
        din_s2: '0,
        raw_s1: 1'b0,
        raw_s2: 1'b0,
        dout: '0,
        ckout: '{dac: CLK_MCLK, adc: CLK_MCLK, tx: CLK_MCLK},
        rdata: '0,
        rvalid: 1'b0
    };

    adr_state_t s_r;
    adr_state_t s_nxt;
    logic [2:0] pri_rx;
    logic dac23_on;

    // pick a source by code; codes outside the field's mask give zero
    function automatic logic pick(input logic [1:0] code, input logic [3:0] mask,
                                  input logic spdif, input logic adc,
                                  input logic sec, input logic pri);
        logic v;
        v = 1'b0;
        if (mask[code]) begin
            case (code)
                `ADR_CODE_SPDIF: v = spdif;
                `ADR_CODE_ADC: v = adc;
                `ADR_CODE_SEC: v = sec;
                default: v = pri;
            endcase
        end
        return v;
    endfunction

    // dac clock: mclk or either pll, never the adc master clock
    function automatic adr_clk_src_t dac_clk_dec(input logic [1:0] f);
        adr_clk_src_t c;
        case (f)
            `ADR_DCLK_PLLA: c = CLK_PLL_A;
            `ADR_DCLK_PLLB: c = CLK_PLL_B;
            default: c = CLK_MCLK;
        endcase
        return c;
    endfunction

    function automatic adr_clk_src_t adc_clk_dec(input logic [1:0] f);
        adr_clk_src_t c;
        case (f)
            `ADR_ACLK_ADC_MASTER_CLOCK_IN: c = CLK_ADC_MCLK;
            `ADR_ACLK_PLLA: c = CLK_PLL_A;
            `ADR_ACLK_PLLB: c = CLK_PLL_B;
            default: c = CLK_MCLK;
        endcase
        return c;
    endfunction

    always_comb begin
        s_nxt = s_r;
        pri_rx = '0;
        dac23_on = 1'b1;

        // pins are asynchronous to clk: two flops before use
        s_nxt.din_s1 = converter_serial_inputs;
        s_nxt.din_s2 = s_r.din_s1;
        s_nxt.raw_s1 = spdif_in_raw;
        s_nxt.raw_s2 = s_r.raw_s1;

        // primary receiver muxes; route code 3 is unused and gives zero
        for (int i = 0; i < 3; i++) begin
            if (dac_pin_route[i] != 2'h3) begin
                pri_rx[i] = s_r.din_s2[dac_pin_route[i]];
            end
        end

        // with s/pdif on dac1 and no common frame clock, dac2/3 are idle
        if (s_r.regs.dac1_src == `ADR_CODE_SPDIF && !receiver_dac_sync_mode) begin
            dac23_on = 1'b0;
        end
        s_nxt.dout.dac23_on = dac23_on;

        s_nxt.dout.dac[0] = pick(s_r.regs.dac1_src, `ADR_MASK_DAC1, src_in.spdif_rx,
                                 src_in.adc, src_in.sec_rx, pri_rx[0]);
        // dac2/3 have no source field at all
        s_nxt.dout.dac[1] = dac23_on & pri_rx[1];
        s_nxt.dout.dac[2] = dac23_on & pri_rx[2];

        s_nxt.dout.pri_tx = pick(s_r.regs.pri_tx_src, `ADR_MASK_PRI_TX, src_in.spdif_rx,
                                 src_in.adc, src_in.sec_rx, 1'b0);
        // primary receiver data means the input steered to dac1
        s_nxt.dout.sec_tx = pick(s_r.regs.sec_tx_src, `ADR_MASK_SEC_TX, src_in.spdif_rx,
                                 src_in.adc, 1'b0, pri_rx[0]);
        s_nxt.dout.spdif_tx = pick(s_r.regs.sptx_src, `ADR_MASK_SPTX, src_in.spdif_rx,
                                   src_in.adc, src_in.sec_rx, pri_rx[0]);
        s_nxt.dout.spdif_pin = s_r.regs.thru ? s_r.raw_s2 : src_in.sptx_serial;

        // clock selects; the override bit hands full control to the user fields
        // pll codes name the divided pll outputs; the dividers sit outside
        s_nxt.ckout.dac = dac_clk_dec(s_r.regs.dac_clk_sel);
        if (!s_r.regs.manual && s_r.regs.dac1_src == `ADR_CODE_SPDIF) begin
            s_nxt.ckout.dac = CLK_PLL_A;
        end
        s_nxt.ckout.adc = adc_clk_dec(s_r.regs.adc_clk_sel);
        // pll a tracks the receiver while dac1 takes s/pdif; keep the adc off it
        if (!s_r.regs.manual && s_r.regs.dac1_src == `ADR_CODE_SPDIF
                && s_nxt.ckout.adc == CLK_PLL_A) begin
            s_nxt.ckout.adc = CLK_MCLK;
        end
        s_nxt.ckout.tx = dac_clk_dec(s_r.regs.tx_clk_sel);
        if (!s_r.regs.manual && s_r.regs.sptx_src == `ADR_CODE_SPDIF) begin
            s_nxt.ckout.tx = CLK_PLL_A;
        end

        // register writes; bits owned by other blocks are not kept here
        if (reg_wr) begin
            case (reg_addr)
                `ADR_OFF_CLK_OVR: s_nxt.regs.manual = reg_wdata[`ADR_MAN_BIT];
                `ADR_OFF_CLK_SEL: begin
                    s_nxt.regs.dac_clk_sel = reg_wdata[`ADR_DACCLK_MSB:`ADR_DACCLK_LSB];
                    s_nxt.regs.adc_clk_sel = reg_wdata[`ADR_ADCCLK_MSB:`ADR_ADCCLK_LSB];
                    s_nxt.regs.tx_clk_sel = reg_wdata[`ADR_TXCLK_MSB:`ADR_TXCLK_LSB];
                end
                `ADR_OFF_PRI_CTRL3: s_nxt.regs.dac1_src = reg_wdata[`ADR_SRC_MSB:`ADR_SRC_LSB];
                `ADR_OFF_PRI_CTRL4: s_nxt.regs.pri_tx_src = reg_wdata[`ADR_SRC_MSB:`ADR_SRC_LSB];
                `ADR_OFF_SEC_CTRL2: s_nxt.regs.sec_tx_src = reg_wdata[`ADR_SRC_MSB:`ADR_SRC_LSB];
                `ADR_OFF_SPTX_CTRL0: begin
                    s_nxt.regs.sptx_src = reg_wdata[`ADR_SPTX_SRC_MSB:`ADR_SPTX_SRC_LSB];
                    s_nxt.regs.thru = reg_wdata[`ADR_THRU_BIT];
                end
                default: ;
            endcase
        end

        // readback of the fields held here; everything else reads zero
        s_nxt.rvalid = reg_rd;
        if (reg_rd) begin
            s_nxt.rdata = '0;
            case (reg_addr)
                `ADR_OFF_CLK_OVR: s_nxt.rdata[`ADR_MAN_BIT] = s_r.regs.manual;
                `ADR_OFF_CLK_SEL: begin
                    s_nxt.rdata[`ADR_DACCLK_MSB:`ADR_DACCLK_LSB] = s_r.regs.dac_clk_sel;
                    s_nxt.rdata[`ADR_ADCCLK_MSB:`ADR_ADCCLK_LSB] = s_r.regs.adc_clk_sel;
                    s_nxt.rdata[`ADR_TXCLK_MSB:`ADR_TXCLK_LSB] = s_r.regs.tx_clk_sel;
                end
                `ADR_OFF_PRI_CTRL3: s_nxt.rdata[`ADR_SRC_MSB:`ADR_SRC_LSB] = s_r.regs.dac1_src;
                `ADR_OFF_PRI_CTRL4: s_nxt.rdata[`ADR_SRC_MSB:`ADR_SRC_LSB] = s_r.regs.pri_tx_src;
                `ADR_OFF_SEC_CTRL2: s_nxt.rdata[`ADR_SRC_MSB:`ADR_SRC_LSB] = s_r.regs.sec_tx_src;
                `ADR_OFF_SPTX_CTRL0: begin
                    s_nxt.rdata[`ADR_SPTX_SRC_MSB:`ADR_SPTX_SRC_LSB] = s_r.regs.sptx_src;
                    s_nxt.rdata[`ADR_THRU_BIT] = s_r.regs.thru;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign data_out = s_r.dout;
    assign clk_sel = s_r.ckout;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    dac1_spdif_a: assert property (
        (s_r.regs.dac1_src == `ADR_CODE_SPDIF) |=> (data_out.dac[0] == $past(src_in.spdif_rx)))
        else $error("dac1 does not follow s/pdif receiver data");

    dac1_reserved_a: assert property (
        (s_r.regs.dac1_src == `ADR_CODE_ADC) |=> !data_out.dac[0])
        else $error("reserved dac1 code passes data");

    dac23_off_a: assert property (
        (s_r.regs.dac1_src == `ADR_CODE_SPDIF && !receiver_dac_sync_mode)
            |=> (data_out.dac[2:1] == 2'h0 && !data_out.dac23_on))
        else $error("dac2/3 not idle with s/pdif on dac1");

    pri_tx_adc_a: assert property (
        (s_r.regs.pri_tx_src == `ADR_CODE_ADC) |=> (data_out.pri_tx == $past(src_in.adc)))
        else $error("primary transmitter does not carry adc data");

    sec_tx_dac1_a: assert property (
        (s_r.regs.sec_tx_src == `ADR_CODE_PRI && s_r.regs.dac1_src == `ADR_CODE_PRI)
            |=> (data_out.sec_tx == data_out.dac[0]))
        else $error("secondary transmitter differs from dac1 pin data");

    sptx_sec_a: assert property (
        (s_r.regs.sptx_src == `ADR_CODE_SEC) |=> (data_out.spdif_tx == $past(src_in.sec_rx)))
        else $error("s/pdif transmitter does not carry secondary data");

    thru_pin_a: assert property (
        (s_r.regs.thru && $past(s_r.regs.thru)) |=> (data_out.spdif_pin == $past(spdif_in_raw, 3)))
        else $error("through mode pin does not follow raw input");

    dac_clk_auto_a: assert property (
        (!s_r.regs.manual && s_r.regs.dac1_src == `ADR_CODE_SPDIF) |=> (clk_sel.dac == CLK_PLL_A))
        else $error("dac clock not forced to pll a");

    dac_clk_manual_a: assert property (
        (s_r.regs.manual && s_r.regs.dac_clk_sel == `ADR_DCLK_PLLB) |=> (clk_sel.dac == CLK_PLL_B))
        else $error("manual dac clock select ignored");

    dac_clk_subset_a: assert property (
        (clk_sel.dac != CLK_ADC_MCLK) && (clk_sel.tx != CLK_ADC_MCLK))
        else $error("adc master clock offered to dac or transmitter");

    dac1_src_wr_a: assert property (
        (reg_wr && reg_addr == `ADR_OFF_PRI_CTRL3)
            |=> (s_r.regs.dac1_src == $past(reg_wdata[`ADR_SRC_MSB:`ADR_SRC_LSB])))
        else $error("dac1 source field write lost");

    sptx_wr_a: assert property (
        (reg_wr && reg_addr == `ADR_OFF_SPTX_CTRL0)
            |=> (s_r.regs.sptx_src == $past(reg_wdata[`ADR_SPTX_SRC_MSB:`ADR_SPTX_SRC_LSB])
                && s_r.regs.thru == $past(reg_wdata[`ADR_THRU_BIT])))
        else $error("s/pdif transmitter control write lost");

    man_wr_a: assert property (
        (reg_wr && reg_addr == `ADR_OFF_CLK_OVR)
            |=> (s_r.regs.manual == $past(reg_wdata[`ADR_MAN_BIT])))
        else $error("manual override write lost");

    clk_sel_wr_a: assert property (
        (reg_wr && reg_addr == `ADR_OFF_CLK_SEL)
            |=> ({s_r.regs.tx_clk_sel, s_r.regs.adc_clk_sel, s_r.regs.dac_clk_sel}
                == $past(reg_wdata[`ADR_TXCLK_MSB:`ADR_DACCLK_LSB])))
        else $error("clock select write lost");

    clk_sel_rd_a: assert property (
        (reg_rd && reg_addr == `ADR_OFF_CLK_SEL)
            |=> (reg_rvalid && reg_rdata[`ADR_TXCLK_MSB:`ADR_DACCLK_LSB]
                == $past({s_r.regs.tx_clk_sel, s_r.regs.adc_clk_sel, s_r.regs.dac_clk_sel})))
        else $error("clock select readback wrong");

    dac1_sec_a: assert property (
        (s_r.regs.dac1_src == `ADR_CODE_SEC) |=> (data_out.dac[0] == $past(src_in.sec_rx)))
        else $error("dac1 does not follow secondary receiver data");

    dac1_pin_a: assert property (
        (s_r.regs.dac1_src == `ADR_CODE_PRI && dac_pin_route[0] != 2'h3)
            |=> (data_out.dac[0] == $past(s_r.din_s2[dac_pin_route[0]])))
        else $error("dac1 does not follow its steered pin");

    dac2_pin_a: assert property (
        (!(s_r.regs.dac1_src == `ADR_CODE_SPDIF && !receiver_dac_sync_mode)
                && dac_pin_route[1] != 2'h3)
            |=> (data_out.dac[1] == $past(s_r.din_s2[dac_pin_route[1]])))
        else $error("dac2 does not follow its steered pin");

    route_none_a: assert property (
        (dac_pin_route[2] == 2'h3) |=> !data_out.dac[2])
        else $error("unrouted dac3 passes data");

    pri_tx_rsvd_a: assert property (
        (s_r.regs.pri_tx_src == `ADR_CODE_PRI) |=> !data_out.pri_tx)
        else $error("reserved primary transmitter code passes data");

    sec_tx_rsvd_a: assert property (
        (s_r.regs.sec_tx_src == `ADR_CODE_SEC) |=> !data_out.sec_tx)
        else $error("reserved secondary transmitter code passes data");

    sptx_pri_a: assert property (
        (s_r.regs.sptx_src == `ADR_CODE_PRI && s_r.regs.dac1_src == `ADR_CODE_PRI)
            |=> (data_out.spdif_tx == data_out.dac[0]))
        else $error("s/pdif transmitter differs from dac1 pin data");

    tx_pin_a: assert property (
        !s_r.regs.thru |=> (data_out.spdif_pin == $past(src_in.sptx_serial)))
        else $error("output pin does not follow the transmitter");

    adc_clk_manual_a: assert property (
        (s_r.regs.manual && s_r.regs.adc_clk_sel == `ADR_ACLK_ADC_MASTER_CLOCK_IN)
            |=> (clk_sel.adc == CLK_ADC_MCLK))
        else $error("manual adc clock select ignored");

    adc_clk_auto_a: assert property (
        (!s_r.regs.manual && s_r.regs.dac1_src == `ADR_CODE_SPDIF)
            |=> (clk_sel.adc != CLK_PLL_A))
        else $error("adc clock left on pll a while it tracks the receiver");

    tx_clk_auto_a: assert property (
        (!s_r.regs.manual && s_r.regs.sptx_src == `ADR_CODE_SPDIF)
            |=> (clk_sel.tx == CLK_PLL_A))
        else $error("transmitter clock not forced to pll a");

    dac_clk_field_a: assert property (
        (s_r.regs.dac1_src != `ADR_CODE_SPDIF && s_r.regs.dac_clk_sel == `ADR_DCLK_PLLA)
            |=> (clk_sel.dac == CLK_PLL_A))
        else $error("dac clock field ignored");

endmodule

// *** adr_host_model.sv ***
// host side model: serial data on the converter pins and on-chip sources
`timescale 1ns/100ps
module adr_host_model
    import adr_pkg::*;
(
    // clock
    input wire logic clk,
    // bench pattern: pins[2:0], raw, spdif_rx, sec_rx, adc, sptx_serial
    input wire logic drive,
    input wire logic [7:0] pat,
    // lines toward the router
    output logic [2:0] pins,
    output logic raw,
    output adr_src_in_t src
);
    logic [7:0] idle_r = 8'h55;
    // released lines toggle every cycle so a stale level never looks valid
    always @(posedge clk) begin
        idle_r <= ~idle_r;
    end
    assign {pins, raw, src} = drive ? pat : idle_r;
endmodule

// *** adr_router_tb.sv ***
// self-checking bench of the audio data router
`timescale 1ns/100ps
module adr_router_tb
    import adr_pkg::*;
;
    logic clk = 0;
    logic rst_n = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic drive = 0;
    logic [7:0] pat = 8'h00;
    logic [2:0][1:0] route = '0;
    logic sync = 1;
    logic [8:0] reg_rdata;
    logic reg_rvalid;
    logic [2:0] pins;
    logic raw;
    adr_src_in_t src;
    adr_data_out_t data_out;
    adr_clk_out_t clk_sel;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    adr_host_model host_u (.clk(clk), .drive(drive), .pat(pat), .pins(pins), .raw(raw),
        .src(src));
    adr_router dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .converter_serial_inputs(pins), .spdif_in_raw(raw),
        .dac_pin_route(route), .receiver_dac_sync_mode(sync), .src_in(src),
        .data_out(data_out), .clk_sel(clk_sel));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // long enough for the pin synchronisers plus the output register
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 0;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
        @(posedge clk);
        #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 0;
        chk("read valid", 9'h001, 9'(reg_rvalid));
        chk("read data", exp, reg_rdata);
        @(posedge clk);
        #1;
        chk("read valid", 9'h000, 9'(reg_rvalid));
        chk("read hold", exp, reg_rdata);
    endtask

    function automatic logic pick(input logic [1:0] c, input logic [3:0] m,
        input logic [3:0] p);
        // undefined codes give a silent path
        return m[c] ? p[c] : 1'b0;
    endfunction

    task automatic t_regs();
        logic [6:0] ad [6] = '{7'h0c, 7'h0d, 7'h0e, 7'h1e, 7'h06, 7'h08};
        logic [8:0] rv [6] = '{9'h180, 9'h080, 9'h000, 9'h000, 9'h000, 9'h000};
        logic [8:0] mk [6] = '{9'h180, 9'h180, 9'h180, 9'h00b, 9'h040, 9'h03f};
        settle();
        chk("tx clk reset", 9'(CLK_PLL_A), 9'(clk_sel.tx));
        chk("dac clk reset", 9'(CLK_MCLK), 9'(clk_sel.dac));
        for (int i = 0; i < 6; i++) begin
            rd_chk(ad[i], rv[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ad[i], 9'h1ff);
            rd_chk(ad[i], mk[i]);
        end
        wr(7'h10, 9'h1ff);
        rd_chk(7'h10, 9'h000);
    endtask

    task automatic t_sources();
        logic [3:0] p;
        logic [1:0] c;
        for (int n = 0; n < 4; n++) begin
            c = 2'(n);
            wr(7'h0c, {c, 7'h00});
            wr(7'h0d, {c, 7'h00});
            wr(7'h0e, {c, 7'h00});
            wr(7'h1e, {7'h00, c});
            for (int k = 0; k < 16; k++) begin
                // p by code: 0 spdif rx, 1 adc, 2 secondary rx, 3 pin of dac1
                p = 4'(k);
                pat = {2'h0, p[3], 1'b0, p[0], p[2], p[1], 1'b0};
                settle();
                chk("dac1 data", 9'(pick(c, 4'hd, p)), 9'(data_out.dac[0]));
                chk("pri tx", 9'(pick(c, 4'h7, p)), 9'(data_out.pri_tx));
                chk("sec tx", 9'(pick(c, 4'hb, p)), 9'(data_out.sec_tx));
                chk("spdif tx", 9'(pick(c, 4'hf, p)), 9'(data_out.spdif_tx));
            end
        end
    endtask

    task automatic t_steer();
        logic [2:0] hot;
        for (int i = 0; i < 3; i++) begin
            // dac1 away on spdif while dac2/3 are steered
            wr(7'h0c, (i == 0) ? 9'h180 : 9'h000);
            for (int j = 0; j < 4; j++) begin
                route = {3{2'h3}};
                route[i] = 2'(j);
                hot = 3'(1 << j);
                pat = {hot, 5'h00};
                settle();
                chk("dac steer", 9'(j < 3), 9'(data_out.dac[i]));
                pat = {~hot, 5'h00};
                settle();
                chk("dac steer", 9'h000, 9'(data_out.dac[i]));
            end
        end
        route = '0;
        sync = 0;
        settle();
        chk("dac23 on", 9'h000, 9'(data_out.dac23_on));
        sync = 1;
        settle();
        chk("dac23 on", 9'h001, 9'(data_out.dac23_on));
    endtask

    task automatic t_thru();
        for (int t = 0; t < 2; t++) begin
            wr(7'h1e, (t != 0) ? 9'h009 : 9'h001);
            for (int v = 0; v < 2; v++) begin
                pat = {3'h0, 1'(v), 3'h0, 1'(1 - v)};
                settle();
                chk("spdif pin", 9'((t != 0) ? v : 1 - v), 9'(data_out.spdif_pin));
            end
        end
    endtask

    task automatic t_clocks();
        logic [4:0] b;
        logic [1:0] f;
        logic [1:0] ed;
        logic [1:0] ea;
        logic [1:0] et;
        for (int n = 0; n < 32; n++) begin
            // b: manual, dac1 on spdif, spdif tx on spdif rx, field code
            b = 5'(n);
            f = b[1:0];
            wr(7'h06, {2'h0, b[4], 6'h00});
            wr(7'h0c, b[3] ? 9'h000 : 9'h180);
            wr(7'h1e, b[2] ? 9'h000 : 9'h003);
            wr(7'h08, {3'h0, f, f, f});
            settle();
            ed = (f == 2'h1) ? 2'h2 : (f == 2'h2) ? 2'h3 : 2'h0;
            ea = f;
            et = ed;
            if (!b[4]) begin
                if (b[3]) begin
                    ed = 2'h2;
                    if (ea == 2'h2) begin
                        ea = 2'h0;
                    end
                end
                if (b[2]) begin
                    et = 2'h2;
                end
            end
            chk("dac clk", 9'(ed), 9'(clk_sel.dac));
            chk("adc clk", 9'(ea), 9'(clk_sel.adc));
            chk("tx clk", 9'(et), 9'(clk_sel.tx));
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1;
        drive = 1;
        t_regs();
        t_sources();
        t_steer();
        t_thru();
        t_clocks();
        conclude();
    end
endmodule
